// File: design/spr_pkg.sv
// Purpose: shared constants and carriers for the sequencer program port block
// Assumes: 8-bit register port, 20 MHz clock
// Notes:   offsets are byte addresses on the plain register port
package spr_pkg;
   // =====================================================
   // register map
   localparam logic [7:0] SPR_OFF_CTRL   = 8'h60;
   localparam logic [7:0] SPR_OFF_DATA   = 8'h61;
   localparam logic [7:0] SPR_OFF_IPLO   = 8'h62;
   localparam logic [7:0] SPR_OFF_IPHI   = 8'h63;
   localparam logic [7:0] SPR_OFF_ACC    = 8'h64;
   localparam logic [7:0] SPR_OFF_SIDX   = 8'h65;
   localparam logic [7:0] SPR_OFF_DIDX   = 8'h66;
   localparam logic [7:0] SPR_OFF_NONE   = 8'h6a;
   localparam logic [7:0] SPR_OFF_HOST   = 8'h70;
   localparam logic [7:0] SPR_OFF_ISTAT  = 8'h71;
   localparam logic [7:0] SPR_OFF_IMASK  = 8'h72;
   // =====================================================
   // field positions and reset values
   localparam int         SPR_CTL_LOAD   = 0;
   localparam int         SPR_CTL_PCLR   = 1;
   localparam int         SPR_CTL_FPD    = 5;
   localparam int         SPR_CTL_PCD    = 7;
   localparam logic [7:0] SPR_CTL_RST    = 8'h00_a0;
   localparam int         SPR_HOST_PAUSE = 2;
   localparam int         SPR_EV_PAR     = 0;
   localparam int         SPR_EV_OPC     = 1;
   localparam logic [7:0] SPR_ZERO8      = 8'h00_00;
   // =====================================================
   // program store geometry and instruction fields
   localparam int          SPR_DEPTH     = 768;
   localparam int          SPR_AW        = 10;
   localparam logic [1:0]  SPR_LANE_MSB  = 2'h3;
   localparam int          SPR_PAR_BIT   = 31;
   // one bit per opcode value, set when the opcode is legal
   localparam logic [15:0] SPR_OPC_LEGAL = 16'h7f_ff;

   typedef struct packed {
      logic              step;       // execute instruction at pointer
      logic              jump;       // redirect pointer
      logic [SPR_AW-1:0] target;     // redirect address
      logic [7:0]        alu;        // alu result
      logic              wr_acc;     // alu result goes to accumulator
      logic              wr_sidx;    // alu result goes to source index
      logic              wr_didx;    // alu result goes to destination index
      logic              src_xfer;   // transfer through source index
      logic              src_port;   // source index addresses a data port
      logic              dst_xfer;   // transfer through destination index
      logic              dst_port;   // destination index addresses a data port
   } spr_exec_t;

   typedef struct packed {
      logic [3:0] opcode;
      logic       is_jump;
      logic [7:0] operand;
      logic [7:0] src_addr;
      logic [7:0] dst_addr;
   } spr_dec_t;
endpackage

// File: design/spr_seq_regs.sv
// Purpose: program store port, instruction pointer, accumulator, index regs
// Assumes: one 20 MHz clock, synchronous resets, host strobes one cycle
// Notes:   the execution core drives exec_i; this block fetches and checks
`timescale 1ns/1ps
`default_nettype none
module spr_seq_regs
   import spr_pkg::*;
(
   input  wire logic       clock_i,           // 20 MHz clock
   input  wire logic       reset_n_i,         // host bus reset, active low
   input  wire logic       soft_chip_reset_i, // chip soft reset, active high
   input  wire logic [7:0] addr_i,            // register address
   input  wire logic [7:0] wdata_i,           // write data
   input  wire logic       wr_i,              // write strobe
   input  wire logic       rd_i,              // read strobe
   output logic [7:0]      rdata_o,           // read data, cycle after rd_i
   input  wire spr_exec_t  exec_i,            // execution core requests
   output spr_dec_t        dec_o,             // decoded fetched instruction
   output logic [7:0]      acc_o,             // accumulator, implicit operand
   output logic [7:0]      sidx_o,            // source index
   output logic [7:0]      didx_o,            // destination index
   output logic            pause_o,           // sequencer held
   output logic            irq_o              // level interrupt
);
   // =====================================================
   // state
   logic [31:0]       store_r [SPR_DEPTH];
   logic [7:0]        ctrl_r;
   logic [SPR_AW-1:0] ptr_r;
   logic [1:0]        lane_r;
   logic [7:0]        acc_r;
   logic [7:0]        sidx_r;
   logic [7:0]        didx_r;
   logic              pause_r;
   logic              par_flt_r;
   logic              opc_flt_r;
   logic [1:0]        istat_r;
   logic [1:0]        imask_r;
   logic [7:0]        rdata_r;
   spr_dec_t          dec_r;

   logic       rst;
   logic       wr_ctrl;
   logic       wr_lo;
   logic       wr_hi;
   logic       port_acc;
   logic       in_range;
   logic       running;
   logic       fetch;
   logic [31:0] word;
   logic       par_bad;
   logic       opc_bad;
   logic       ev_par;
   logic       ev_opc;
   logic [1:0] ev;

   assign rst      = !reset_n_i || soft_chip_reset_i;
   assign wr_ctrl  = wr_i && (addr_i == SPR_OFF_CTRL);
   assign wr_lo    = wr_i && (addr_i == SPR_OFF_IPLO);
   assign wr_hi    = wr_i && (addr_i == SPR_OFF_IPHI);
   assign in_range = (ptr_r < SPR_AW'(SPR_DEPTH));
   // only a loading host may touch the store
   assign port_acc = ctrl_r[SPR_CTL_LOAD] && (addr_i == SPR_OFF_DATA)
                     && (wr_i || rd_i);
   assign running  = !pause_r && !ctrl_r[SPR_CTL_LOAD];
   assign fetch    = exec_i.step && running;
   assign word     = in_range ? store_r[ptr_r] : 32'h0000_0000;
   assign par_bad  = !(^word);
   assign opc_bad  = !SPR_OPC_LEGAL[word[30:27]];
   assign ev_par   = fetch && par_bad && !ctrl_r[SPR_CTL_PCD]
                     && !ctrl_r[SPR_CTL_FPD];
   assign ev_opc   = fetch && opc_bad && !ctrl_r[SPR_CTL_FPD];
   assign ev       = {ev_opc, ev_par};

   // =====================================================
   // control register
   always_ff @(posedge clock_i) begin
      if (rst) begin
         ctrl_r <= SPR_CTL_RST;
      end else if (wr_ctrl) begin
         // pointer_clear is self-clearing, so never stored
         ctrl_r <= wdata_i & ~(8'h00_01 << SPR_CTL_PCLR);
      end
   end

   // =====================================================
   // program store, byte lanes written in place
   always_ff @(posedge clock_i) begin
      if (port_acc && wr_i && in_range) begin
         store_r[ptr_r][lane_r*8 +: 8] <= wdata_i;
      end
   end

   // =====================================================
   // instruction pointer and byte lane
   always_ff @(posedge clock_i) begin
      if (rst || (wr_ctrl && wdata_i[SPR_CTL_PCLR])) begin
         ptr_r  <= '0;
         lane_r <= '0;
      end else if (wr_lo) begin
         ptr_r[7:0] <= wdata_i;
         lane_r     <= '0;
      end else if (wr_hi) begin
         ptr_r[9:8] <= wdata_i[1:0];
         lane_r     <= '0;
      end else if (port_acc) begin
         lane_r <= lane_r + 2'd1;
         if (lane_r == SPR_LANE_MSB) begin
            ptr_r <= ptr_r + SPR_AW'(1);
         end
      end else if (exec_i.jump && running) begin
         ptr_r <= exec_i.target;
      end else if (fetch) begin
         ptr_r <= ptr_r + SPR_AW'(1);
      end
   end

   // =====================================================
   // fetch and decode
   always_ff @(posedge clock_i) begin
      if (rst) begin
         dec_r <= '0;
      end else if (fetch) begin
         dec_r.opcode   <= word[30:27];
         dec_r.is_jump  <= word[26];
         dec_r.operand  <= (word[7:0] == SPR_ZERO8) ? acc_r : word[7:0];
         dec_r.src_addr <= word[15:8];
         // jumps carry the next address here, so the sink is the null port
         dec_r.dst_addr <= word[26] ? SPR_OFF_NONE : word[23:16];
      end
   end

   // =====================================================
   // faults, pause
   always_ff @(posedge clock_i) begin
      if (rst) begin
         par_flt_r <= 1'b0;
         opc_flt_r <= 1'b0;
      end else begin
         // a new fault wins over the clear
         if (ev_par) begin
            par_flt_r <= 1'b1;
         end else if (wr_ctrl && wdata_i[SPR_CTL_LOAD]) begin
            par_flt_r <= 1'b0;
         end
         if (ev_opc) begin
            opc_flt_r <= 1'b1;
         end else if (wr_ctrl && wdata_i[SPR_CTL_LOAD]) begin
            opc_flt_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst) begin
         pause_r <= 1'b0;
      end else if (ev_par || ev_opc) begin
         pause_r <= 1'b1;
      end else if (wr_i && addr_i == SPR_OFF_HOST) begin
         pause_r <= wdata_i[SPR_HOST_PAUSE];
      end
   end

   // =====================================================
   // interrupt status and mask
   always_ff @(posedge clock_i) begin
      if (rst) begin
         istat_r <= '0;
         imask_r <= '0;
      end else begin
         if (wr_i && addr_i == SPR_OFF_IMASK) begin
            imask_r <= wdata_i[1:0];
         end
         if (wr_i && addr_i == SPR_OFF_ISTAT) begin
            istat_r <= (istat_r & ~wdata_i[1:0]) | ev;
         end else begin
            istat_r <= istat_r | ev;
         end
      end
   end

   // =====================================================
   // accumulator and index registers
   always_ff @(posedge clock_i) begin
      if (rst) begin
         acc_r <= '0;
      end else if (wr_i && addr_i == SPR_OFF_ACC) begin
         acc_r <= wdata_i;
      end else if (exec_i.wr_acc && running) begin
         acc_r <= exec_i.alu;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst) begin
         sidx_r <= '0;
      end else if (wr_i && addr_i == SPR_OFF_SIDX) begin
         sidx_r <= wdata_i;
      end else if ((exec_i.wr_sidx || (dec_r.is_jump && exec_i.jump)) && running) begin
         sidx_r <= exec_i.alu;
      end else if (exec_i.src_xfer && !exec_i.src_port && running) begin
         sidx_r <= sidx_r + 8'd1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst) begin
         didx_r <= '0;
      end else if (wr_i && addr_i == SPR_OFF_DIDX) begin
         didx_r <= wdata_i;
      end else if (exec_i.wr_didx && running) begin
         didx_r <= exec_i.alu;
      end else if (exec_i.dst_xfer && !exec_i.dst_port && running) begin
         didx_r <= didx_r + 8'd1;
      end
   end

   // =====================================================
   // read port, unmapped addresses read zero
   always_ff @(posedge clock_i) begin
      if (rst || !rd_i) begin
         rdata_r <= '0;
      end else begin
         case (addr_i)
            SPR_OFF_CTRL:  rdata_r <= ctrl_r;
            SPR_OFF_DATA:  rdata_r <= port_acc ? word[lane_r*8 +: 8] : SPR_ZERO8;
            SPR_OFF_IPLO:  rdata_r <= ptr_r[7:0];
            SPR_OFF_IPHI:  rdata_r <= {6'b0, ptr_r[9:8]};
            SPR_OFF_ACC:   rdata_r <= acc_r;
            SPR_OFF_SIDX:  rdata_r <= sidx_r;
            SPR_OFF_DIDX:  rdata_r <= didx_r;
            SPR_OFF_HOST:  rdata_r <= {5'b0, pause_r, opc_flt_r, par_flt_r};
            SPR_OFF_ISTAT: rdata_r <= {6'b0, istat_r};
            SPR_OFF_IMASK: rdata_r <= {6'b0, imask_r};
            default:       rdata_r <= SPR_ZERO8;
         endcase
      end
   end

   assign rdata_o = rdata_r;
   assign dec_o   = dec_r;
   assign acc_o   = acc_r;
   assign sidx_o  = sidx_r;
   assign didx_o  = didx_r;
   assign pause_o = pause_r;
   assign irq_o   = |(istat_r & imask_r);

   // =====================================================
   // checks
   chk_ptr_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (wr_ctrl && wdata_i[SPR_CTL_PCLR]) |=> (ptr_r == '0))
      else $error("pointer not cleared");
   chk_ptr_adv: assert property (@(posedge clock_i) disable iff (rst)
      (port_acc && lane_r == SPR_LANE_MSB && !wr_lo && !wr_hi && !wr_ctrl)
      |=> (ptr_r == $past(ptr_r) + SPR_AW'(1)))
      else $error("pointer did not advance after msb");
   chk_ptr_hold: assert property (@(posedge clock_i) disable iff (rst)
      (port_acc && lane_r != SPR_LANE_MSB) |=> $stable(ptr_r))
      else $error("pointer moved mid word");
   chk_lane_rst: assert property (@(posedge clock_i) disable iff (rst)
      (wr_lo || wr_hi) |=> (lane_r == 2'd0))
      else $error("lane not reset");
   chk_par_pause: assert property (@(posedge clock_i) disable iff (rst)
      ev_par |=> (pause_r && par_flt_r))
      else $error("parity fault not latched");
   chk_opc_pause: assert property (@(posedge clock_i) disable iff (rst)
      ev_opc |=> (pause_r && opc_flt_r))
      else $error("opcode fault not latched");
   chk_flt_keep: assert property (@(posedge clock_i) disable iff (rst)
      (par_flt_r && !(wr_ctrl && wdata_i[SPR_CTL_LOAD])) |=> par_flt_r)
      else $error("parity fault lost");
   chk_hi_rsvd: assert property (@(posedge clock_i) disable iff (rst)
      (rd_i && addr_i == SPR_OFF_IPHI) |=> (rdata_o[7:2] == 6'b0))
      else $error("reserved pointer bits set");
   chk_acc_hold: assert property (@(posedge clock_i) disable iff (rst)
      (!exec_i.wr_acc && !(wr_i && addr_i == SPR_OFF_ACC)) |=> $stable(acc_r))
      else $error("accumulator changed");
   chk_sidx_port: assert property (@(posedge clock_i) disable iff (rst)
      (running && exec_i.src_xfer && exec_i.src_port && !exec_i.wr_sidx && !exec_i.jump
       && !wr_i) |=> $stable(sidx_r))
      else $error("source index moved on port");
   chk_didx_inc: assert property (@(posedge clock_i) disable iff (rst)
      (running && exec_i.dst_xfer && !exec_i.dst_port && !exec_i.wr_didx && !wr_i)
      |=> (didx_r == $past(didx_r) + 8'd1))
      else $error("destination index did not increment");
   chk_imm_acc: assert property (@(posedge clock_i) disable iff (rst)
      (fetch && word[7:0] == SPR_ZERO8) |=> (dec_r.operand == $past(acc_r)))
      else $error("zero immediate not replaced");
   chk_jump_null: assert property (@(posedge clock_i) disable iff (rst)
      (fetch && word[26]) |=> (dec_r.dst_addr == SPR_OFF_NONE))
      else $error("jump destination not null");
   chk_ctrl_pclr: assert property (@(posedge clock_i) disable iff (rst)
      wr_ctrl |=> !ctrl_r[SPR_CTL_PCLR])
      else $error("pointer clear bit stored");
   chk_lane_lock: assert property (@(posedge clock_i) disable iff (rst)
      (!ctrl_r[SPR_CTL_LOAD] && !wr_lo && !wr_hi && !wr_ctrl) |=> $stable(lane_r))
      else $error("byte lane moved while not loading");
   chk_flt_clear: assert property (@(posedge clock_i) disable iff (rst)
      (wr_ctrl && wdata_i[SPR_CTL_LOAD] && !ev_par && !ev_opc)
      |=> (!par_flt_r && !opc_flt_r))
      else $error("faults not cleared by load enable");
   chk_opc_keep: assert property (@(posedge clock_i) disable iff (rst)
      (opc_flt_r && !(wr_ctrl && wdata_i[SPR_CTL_LOAD])) |=> opc_flt_r)
      else $error("opcode fault lost");
   chk_par_off: assert property (@(posedge clock_i) disable iff (rst)
      (ctrl_r[SPR_CTL_PCD] && !par_flt_r) |=> !par_flt_r)
      else $error("parity fault while checking disabled");
   chk_fpd_hold: assert property (@(posedge clock_i) disable iff (rst)
      (ctrl_r[SPR_CTL_FPD] && !pause_r && !(wr_i && addr_i == SPR_OFF_HOST)) |=> !pause_r)
      else $error("fault paused while pausing disabled");
   chk_acc_load: assert property (@(posedge clock_i) disable iff (rst)
      (running && exec_i.wr_acc && !(wr_i && addr_i == SPR_OFF_ACC))
      |=> (acc_r == $past(exec_i.alu)))
      else $error("accumulator not loaded from alu");
   chk_sidx_jump: assert property (@(posedge clock_i) disable iff (rst)
      (running && exec_i.jump && dec_r.is_jump && !(wr_i && addr_i == SPR_OFF_SIDX))
      |=> (sidx_r == $past(exec_i.alu)))
      else $error("jump result not in source index");
   chk_sidx_inc: assert property (@(posedge clock_i) disable iff (rst)
      (running && exec_i.src_xfer && !exec_i.src_port && !exec_i.wr_sidx && !exec_i.jump
       && !wr_i) |=> (sidx_r == $past(sidx_r) + 8'd1))
      else $error("source index did not increment");
   chk_didx_port: assert property (@(posedge clock_i) disable iff (rst)
      (running && exec_i.dst_xfer && exec_i.dst_port && !exec_i.wr_didx && !wr_i)
      |=> $stable(didx_r))
      else $error("destination index moved on port");
   chk_ptr_jump: assert property (@(posedge clock_i) disable iff (rst)
      (running && exec_i.jump && !wr_i) |=> (ptr_r == $past(exec_i.target)))
      else $error("pointer not redirected");
   chk_fetch_adv: assert property (@(posedge clock_i) disable iff (rst)
      (fetch && !exec_i.jump && !wr_i) |=> (ptr_r == $past(ptr_r) + SPR_AW'(1)))
      else $error("pointer did not step after fetch");
endmodule
`default_nettype wire

// File: dv/spr_core_model.sv
// Purpose: stand-in for the sequencer execution core driving exec_i
// Assumes: one clock, requests are levels held for exactly one cycle
// Notes:   lag lets the bench present a request promptly or late
`timescale 1ns/1ps
`default_nettype none
module spr_core_model
   import spr_pkg::*;
(
   input  wire logic clock_i, // 20 MHz clock
   output spr_exec_t  exec_o  // request to the register block
);
   initial exec_o = '0;

   // =====================================================
   // one request, idle again afterwards so nothing repeats by accident
   task automatic issue(input spr_exec_t e, input int lag);
      repeat (lag) @(posedge clock_i);
      @(posedge clock_i);
      exec_o <= e;
      @(posedge clock_i);
      exec_o <= '0;
   endtask
endmodule
`default_nettype wire

// File: dv/spr_seq_regs_test.sv
// Purpose: self-checking bench for the program port and index registers
// Assumes: read data valid only in the cycle after the read strobe
// Notes:   expectations come from bench functions, never from the design
`timescale 1ns/1ps
`default_nettype none
module spr_seq_regs_test;
   import spr_pkg::*;
   logic        clock_i, reset_n_i, soft_rst, wr, rd, pause, irq;
   logic [7:0]  addr, wdata, rdata, acc, sidx, didx, v, u;
   spr_dec_t    dec;
   spr_exec_t   exec, e;
   logic [31:0] w [4];
   integer      num_errors, n_tests, seed, k, b;
   logic [7:0]  rst_offs [7];

   spr_seq_regs spr_seq_regs_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .soft_chip_reset_i(soft_rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .exec_i(exec), .dec_o(dec), .acc_o(acc), .sidx_o(sidx),
      .didx_o(didx), .pause_o(pause), .irq_o(irq));
   spr_core_model spr_core_model_inst (.clock_i(clock_i), .exec_o(exec));

   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // =====================================================
   // helpers
   function automatic logic [31:0] mkw(logic [3:0] o, logic j, logic [7:0] d, s, i);
      logic [31:0] x;
      x = {1'b0, o, j, 2'b00, d, s, i};
      x[SPR_PAR_BIT] = ~^x[30:0];
      return x;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_i);
      wr    <= 1'b0;
      // let the write land before callers look at outputs
      #1;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      @(posedge clock_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock_i);
      rd   <= 1'b0;
      #1;
      chk({24'h0000_0000, rdata}, {24'h0000_0000, x});
   endtask

   task automatic run(input spr_exec_t r, input int lag);
      spr_core_model_inst.issue(r, lag);
      #1;
   endtask

   task automatic stop_test;
      $display("checks %0d, errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      #2_000_000;
      num_errors++;
      stop_test;
   end

   // =====================================================
   // main sequence
   initial begin
      num_errors = 0;
      n_tests = 0;
      seed = 93437;
      reset_n_i = 1'b0;
      soft_rst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h0000;
      wdata = 8'h0000;
      repeat (16) @(posedge clock_i);
      reset_n_i <= 1'b1;
      rdc(SPR_OFF_CTRL, SPR_CTL_RST);
      rst_offs = '{SPR_OFF_IPLO, SPR_OFF_IPHI, SPR_OFF_ACC, SPR_OFF_SIDX, SPR_OFF_DIDX,
                   SPR_OFF_ISTAT, 8'h007f};
      for (k = 0; k < 7; k++) rdc(rst_offs[k], SPR_ZERO8);
      v = 8'($random(seed));
      w[0] = mkw(4'h2, 1'b0, 8'h0034, 8'h0012, v | 8'h0001);
      w[1] = w[0] ^ 32'h8000_0000;
      w[2] = mkw(4'hf, 1'b0, 8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
      w[3] = mkw(4'h1, 1'b1, 8'h0000, 8'($random(seed)), 8'h0000);
      // load four words at pointer 5, low byte first
      wrr(SPR_OFF_CTRL, 8'h0001);
      wrr(SPR_OFF_IPLO, 8'h0005);
      wrr(SPR_OFF_IPHI, 8'h0000);
      for (k = 0; k < 4; k++) for (b = 0; b < 4; b++) wrr(SPR_OFF_DATA, w[k][8*b+:8]);
      rdc(SPR_OFF_IPLO, 8'h0009);
      // a word read one byte in then a pointer write must restart at byte zero
      wrr(SPR_OFF_IPLO, 8'h0005);
      rdc(SPR_OFF_DATA, w[0][7:0]);
      wrr(SPR_OFF_IPLO, 8'h0005);
      for (k = 0; k < 4; k++) for (b = 0; b < 4; b++) rdc(SPR_OFF_DATA, w[k][8*b+:8]);
      rdc(SPR_OFF_IPLO, 8'h0009);
      wrr(SPR_OFF_IPHI, 8'h00ff);
      rdc(SPR_OFF_IPHI, 8'h0003);
      rdc(SPR_OFF_DATA, SPR_ZERO8);
      wrr(SPR_OFF_CTRL, 8'h0003);
      rdc(SPR_OFF_IPHI, 8'h0000);
      rdc(SPR_OFF_CTRL, 8'h0001);
      wrr(SPR_OFF_IPLO, 8'h0033);
      @(posedge clock_i);
      soft_rst <= 1'b1;
      @(posedge clock_i);
      soft_rst <= 1'b0;
      rdc(SPR_OFF_IPLO, SPR_ZERO8);
      rdc(SPR_OFF_CTRL, SPR_CTL_RST);
      // =====================================================
      // execution: fetch, parity and opcode faults
      u = 8'($random(seed));
      wrr(SPR_OFF_ACC, u);
      wrr(SPR_OFF_CTRL, 8'h0080);
      rdc(SPR_OFF_DATA, SPR_ZERO8);
      wrr(SPR_OFF_IPLO, 8'h0005);
      e = '0;
      e.step = 1'b1;
      run(e, 0);
      chk({dec.opcode, dec.is_jump, dec.operand, dec.src_addr, dec.dst_addr},
          {4'h2, 1'b0, w[0][7:0], 8'h0012, 8'h0034});
      run(e, 2);
      chk(pause, 1'b0);
      wrr(SPR_OFF_CTRL, SPR_ZERO8);
      wrr(SPR_OFF_IMASK, 8'h0003);
      wrr(SPR_OFF_IPLO, 8'h0006);
      run(e, 0);
      chk({pause, irq}, 2'b11);
      rdc(SPR_OFF_HOST, 8'h0005);
      rdc(SPR_OFF_ISTAT, 8'h0001);
      wrr(SPR_OFF_ISTAT, 8'h0001);
      chk(irq, 1'b0);
      wrr(SPR_OFF_HOST, SPR_ZERO8);
      rdc(SPR_OFF_HOST, 8'h0001);
      wrr(SPR_OFF_IMASK, SPR_ZERO8);
      wrr(SPR_OFF_IPLO, 8'h0007);
      run(e, 1);
      rdc(SPR_OFF_HOST, 8'h0007);
      chk(irq, 1'b0);
      wrr(SPR_OFF_IMASK, 8'h0002);
      chk(irq, 1'b1);
      wrr(SPR_OFF_CTRL, 8'h0001);
      rdc(SPR_OFF_HOST, 8'h0004);
      wrr(SPR_OFF_ISTAT, 8'h0003);
      wrr(SPR_OFF_HOST, SPR_ZERO8);
      wrr(SPR_OFF_CTRL, SPR_ZERO8);
      chk({pause, irq}, 2'b00);
      // =====================================================
      // jump word, accumulator and index registers
      wrr(SPR_OFF_IPLO, 8'h0008);
      run(e, 0);
      chk({dec.is_jump, dec.operand, dec.dst_addr}, {1'b1, u, SPR_OFF_NONE});
      v = 8'($random(seed));
      // no explicit select: a jump still lands its result in the source index
      e = '0;
      e.jump = 1'b1;
      e.target = 10'h002a;
      e.alu = v;
      run(e, 3);
      chk(sidx, v);
      rdc(SPR_OFF_IPLO, 8'h002a);
      e = '0;
      e.alu = ~u;
      run(e, 0);
      chk(acc, u);
      e.wr_acc = 1'b1;
      run(e, 1);
      chk(acc, 8'(~u));
      wrr(SPR_OFF_SIDX, 8'h00ff);
      e = '0;
      e.src_xfer = 1'b1;
      run(e, 0);
      chk(sidx, SPR_ZERO8);
      e.src_port = 1'b1;
      run(e, 2);
      chk(sidx, SPR_ZERO8);
      wrr(SPR_OFF_DIDX, v);
      e = '0;
      e.dst_xfer = 1'b1;
      run(e, 0);
      chk(didx, 8'(v + 8'h0001));
      e.dst_port = 1'b1;
      run(e, 1);
      chk(didx, 8'(v + 8'h0001));
      e = '0;
      e.alu = u;
      e.wr_sidx = 1'b1;
      e.wr_didx = 1'b1;
      run(e, 0);
      chk(sidx, u);
      chk(didx, u);
      stop_test;
   end
endmodule
`default_nettype wire
